/* logic/cmr_pkg.sv */
// Purpose: constants and types for the coding-mode and restart control bank
// Assumes: byte addresses on a 32-bit avalon-mm slave, 125 MHz clock
// Notes: compressor bank at 0x00, expander bank at 0x40
package cmr_pkg;
  // master control fields
  localparam int GO_BIT = 0;
  localparam int OP_LO = 1;
  localparam int IE_BIT = 3;
  localparam int DC_BIT = 4;
  localparam int SC_BIT = 5;
  localparam int MC_LO = 6;
  localparam logic [1:0] MODE_TRANSPARENT = 2'h0;
  localparam logic [1:0] MODE_ONE_DIM = 2'h1;
  localparam logic [1:0] MODE_TWO_DIM = 2'h2;
  localparam logic [1:0] OP_RESET = 2'h0;
  localparam logic [1:0] OP_SINGLE = 2'h1;
  localparam logic [1:0] OP_MULTI = 2'h2;
  // restart control bits
  localparam int RC_SRC_COUNT = 0;
  localparam int RC_SRC_ADDR = 1;
  localparam int RC_DST_COUNT = 2;
  localparam int RC_DST_ADDR = 3;
  localparam int RC_UNALIGNED = 5;
  localparam int RC_SRC_LS = 6;
  localparam int RC_DST_LS = 7;
  localparam logic [7:0] RC_MASK_COMP = 8'hcf;
  localparam logic [7:0] RC_MASK_EXP = 8'hef;
  // parameter register fields
  localparam int PAR_EOL_CTRL = 8;
  localparam int PAR_AUTO_EOL = 9;
  // register indices (byte address = 4 * index + bank base)
  localparam logic [3:0] REG_MASTER = 4'h0;
  localparam logic [3:0] REG_RESTART = 4'h1;
  localparam logic [3:0] REG_PARAM = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_SC_HOLD = 4'h4;
  localparam logic [3:0] REG_SA_HOLD = 4'h5;
  localparam logic [3:0] REG_DC_HOLD = 4'h6;
  localparam logic [3:0] REG_DA_HOLD = 4'h7;
  localparam logic [3:0] REG_SC_WORK = 4'h8;
  localparam logic [3:0] REG_SA_CUR = 4'h9;
  localparam logic [3:0] REG_DC_WORK = 4'ha;
  localparam logic [3:0] REG_DA_CUR = 4'hb;
  localparam logic [3:0] REG_SLS = 4'hc;
  localparam logic [3:0] REG_DLS = 4'hd;
  localparam int BANK_BIT = 6;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_ILLEGAL = 1;
  localparam int ST_SRC_OVF = 2;
  localparam int ST_DST_OVF = 3;
  localparam int ST_LINE_2D = 4;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int RESET_TIME_NS = 4000;
  localparam int RESET_CYCLES = (RESET_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int FIFO_DEPTH = 3;
  typedef enum logic [1:0] {run_idle, run_reset, run_active} cmr_run_type;
  // coding controls presented to the datapath
  typedef struct packed {
    logic pass_through;
    logic one_dim;
    logic two_dim;
    logic eol_insert;
    logic eol_byte_pad;
    logic wrap_enable;
    logic line_is_2d;
    logic ref_read;
    logic unaligned_code_flag;
    logic src_doc;
    logic dst_doc;
  } cmr_ctl_type;
  typedef struct packed {
    logic [7:0] mcr;
    logic [7:0] rcr;
    logic [9:0] par;
    logic [15:0] sc_hold;
    logic [15:0] sa_hold;
    logic [15:0] dc_hold;
    logic [15:0] da_hold;
    logic [15:0] sc_work;
    logic [15:0] sa_cur;
    logic [15:0] dc_work;
    logic [15:0] da_cur;
    logic [15:0] source_line_start_keep;
    logic [15:0] destination_line_start_keep;
    logic [15:0] ref_ls;
    logic [7:0] k_work;
    logic next_2d;
    cmr_run_type run;
    logic [8:0] timer;
    logic busy;
    logic illegal;
    logic src_ovf;
    logic dst_ovf;
    cmr_ctl_type ctl;
  } cmr_proc_type;
endpackage

/* logic/cmr_byte_fifo.sv */
// Purpose: three-byte shift fifo on the compressor document input
// Assumes: push and pop from logic on clk
// Notes: flush empties it in one cycle
`timescale 1ns/1ps
module cmr_byte_fifo (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic [cmr_pkg::FIFO_DEPTH-1:0][7:0] ent;
    logic [1:0] count;
    logic in_ready;
    logic out_valid;
  } cmr_fifo_type;
  cmr_fifo_type s;
  cmr_fifo_type next_s;
  logic push;
  logic pop;

  // shift on pop, write at the tail on push
  always_comb begin
    next_s = s;
    pop = s.out_valid && out_ready;
    push = in_valid && s.in_ready;
    if (pop) begin
      for (int i = 0; i < cmr_pkg::FIFO_DEPTH - 1; i++) begin
        next_s.ent[i] = s.ent[i+1];
      end
      next_s.count = s.count - 2'h1;
    end
    if (push) begin
      next_s.ent[next_s.count] = in_data;
      next_s.count = next_s.count + 2'h1;
    end
    if (flush) begin
      next_s.count = 2'h0;
    end
    next_s.in_ready = next_s.count < 2'(cmr_pkg::FIFO_DEPTH);
    next_s.out_valid = next_s.count != 2'h0; // registered so the output comes from a flop
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_data = s.ent[0];
endmodule

/* logic/cmr_coding_control.sv */
// Purpose: master and restart control banks for compressor and expander
// Assumes: avalon-mm slave, one wait cycle per access; datapath events on clk
// Notes: index 0 is the compressor, index 1 the expander
`timescale 1ns/1ps
module cmr_coding_control (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // datapath events, one-cycle pulses per processor
  input wire logic [1:0] src_xfer,
  input wire logic [1:0] dst_xfer,
  input wire logic [1:0] line_done,
  input wire logic tag_bit,
  // datapath controls per processor
  output logic [1:0] busy,
  output logic [1:0] interrupt_enable_bit,
  output cmr_pkg::cmr_ctl_type [1:0] ctl,
  output logic [1:0][15:0] src_addr,
  output logic [1:0][15:0] dst_addr,
  output logic [1:0][15:0] ref_addr,
  // compressor document input fifo
  input wire logic doc_in_valid,
  input wire logic [7:0] doc_in_data,
  output logic doc_in_ready,
  output logic doc_out_valid,
  output logic [7:0] doc_out_data,
  input wire logic doc_out_ready
);
  typedef struct packed {
    cmr_pkg::cmr_proc_type [1:0] proc;
    logic waitrequest;
    logic [31:0] readdata;
    logic flush;
  } cmr_top_type;
  cmr_top_type s;
  cmr_top_type next_s;
  logic [31:0] wv;
  logic [31:0] rv;
  logic start;
  logic fin;
  logic g3;
  logic g4;
  logic [1:0] mode;
  logic [1:0] op;
  logic [15:0] sum;

  // byte-lane merge of a write into an existing value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // read multiplexer of one bank
  function automatic logic [31:0] bank_read(input cmr_pkg::cmr_proc_type p, input logic [3:0] idx);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (idx)
      cmr_pkg::REG_MASTER: r[7:0] = p.mcr;
      cmr_pkg::REG_RESTART: r[7:0] = p.rcr;
      cmr_pkg::REG_PARAM: r[9:0] = p.par;
      cmr_pkg::REG_STATUS: begin
        r[cmr_pkg::ST_BUSY] = p.busy;
        r[cmr_pkg::ST_ILLEGAL] = p.illegal;
        r[cmr_pkg::ST_SRC_OVF] = p.src_ovf;
        r[cmr_pkg::ST_DST_OVF] = p.dst_ovf;
        r[cmr_pkg::ST_LINE_2D] = p.ctl.line_is_2d;
      end
      cmr_pkg::REG_SC_HOLD: r[15:0] = p.sc_hold;
      cmr_pkg::REG_SA_HOLD: r[15:0] = p.sa_hold;
      cmr_pkg::REG_DC_HOLD: r[15:0] = p.dc_hold;
      cmr_pkg::REG_DA_HOLD: r[15:0] = p.da_hold;
      cmr_pkg::REG_SC_WORK: r[15:0] = p.sc_work;
      cmr_pkg::REG_SA_CUR: r[15:0] = p.sa_cur;
      cmr_pkg::REG_DC_WORK: r[15:0] = p.dc_work;
      cmr_pkg::REG_DA_CUR: r[15:0] = p.da_cur;
      cmr_pkg::REG_SLS: r[15:0] = p.source_line_start_keep;
      cmr_pkg::REG_DLS: r[15:0] = p.destination_line_start_keep;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // bus handshake, register writes and both processors' sequencing
  always_comb begin
    next_s = s;
    wv = 32'h0000_0000;
    rv = 32'h0000_0000;
    start = 1'b0;
    fin = 1'b0;
    g3 = 1'b0;
    g4 = 1'b0;
    mode = 2'h0;
    op = 2'h0;
    sum = 16'h0000;
    next_s.flush = 1'b0;
    // waitrequest drops for one cycle after a request is seen
    next_s.waitrequest = !((read || write) && s.waitrequest);
    if (read && s.waitrequest) begin
      if (!address[7]) begin
        rv = bank_read(s.proc[address[cmr_pkg::BANK_BIT]], address[5:2]);
      end
      next_s.readdata = rv;
    end
    for (int p = 0; p < 2; p++) begin
      start = 1'b0;
      fin = 1'b0;
      // software writes, taken on the accepting edge
      if (write && !s.waitrequest && !address[7] && (int'(address[cmr_pkg::BANK_BIT]) == p)) begin
        case (address[5:2])
          cmr_pkg::REG_MASTER: begin
            wv = merge({24'h00_0000, s.proc[p].mcr}, writedata, byteenable);
            if (s.proc[p].busy) begin
              // loading master control while busy terminates with an error
              next_s.proc[p].illegal = 1'b1;
              next_s.proc[p].run = cmr_pkg::run_idle;
              next_s.proc[p].mcr = wv[7:0] & ~8'h01;
            end else begin
              next_s.proc[p].mcr = wv[7:0];
              start = wv[cmr_pkg::GO_BIT];
            end
          end
          cmr_pkg::REG_RESTART: begin
            wv = merge({24'h00_0000, s.proc[p].rcr}, writedata, byteenable);
            next_s.proc[p].rcr = wv[7:0] & ((p == 0) ? cmr_pkg::RC_MASK_COMP : cmr_pkg::RC_MASK_EXP);
          end
          cmr_pkg::REG_PARAM: begin
            wv = merge({22'h00_0000, s.proc[p].par}, writedata, byteenable);
            next_s.proc[p].par = wv[9:0];
          end
          cmr_pkg::REG_SC_HOLD: begin
            wv = merge({16'h0000, s.proc[p].sc_hold}, writedata, byteenable);
            next_s.proc[p].sc_hold = wv[15:0];
          end
          cmr_pkg::REG_SA_HOLD: begin
            wv = merge({16'h0000, s.proc[p].sa_hold}, writedata, byteenable);
            next_s.proc[p].sa_hold = wv[15:0];
          end
          cmr_pkg::REG_DC_HOLD: begin
            wv = merge({16'h0000, s.proc[p].dc_hold}, writedata, byteenable);
            next_s.proc[p].dc_hold = wv[15:0];
          end
          cmr_pkg::REG_DA_HOLD: begin
            wv = merge({16'h0000, s.proc[p].da_hold}, writedata, byteenable);
            next_s.proc[p].da_hold = wv[15:0];
          end
          default: begin
            wv = 32'h0000_0000;
          end
        endcase
      end
      mode = s.proc[p].mcr[cmr_pkg::MC_LO +: 2];
      op = s.proc[p].mcr[cmr_pkg::OP_LO +: 2];
      g4 = (mode == cmr_pkg::MODE_TWO_DIM) && s.proc[p].par[cmr_pkg::PAR_EOL_CTRL];
      g3 = (mode == cmr_pkg::MODE_TWO_DIM) && !s.proc[p].par[cmr_pkg::PAR_EOL_CTRL];
      case (s.proc[p].run)
        cmr_pkg::run_reset: begin
          next_s.proc[p].timer = s.proc[p].timer - 9'h001;
          if (s.proc[p].timer == 9'h001) begin
            fin = 1'b1;
          end
        end
        cmr_pkg::run_active: begin
          if (src_xfer[p]) begin
            sum = s.proc[p].sc_work + 16'h0001;
            next_s.proc[p].sc_work = sum;
            next_s.proc[p].sa_cur = s.proc[p].sa_cur + 16'h0001;
            if (sum == 16'h0000) begin
              next_s.proc[p].src_ovf = 1'b1;
              fin = 1'b1;
            end
          end
          if (dst_xfer[p]) begin
            sum = s.proc[p].dc_work + 16'h0001;
            next_s.proc[p].dc_work = sum;
            next_s.proc[p].da_cur = s.proc[p].da_cur + 16'h0001;
            if (sum == 16'h0000) begin
              next_s.proc[p].dst_ovf = 1'b1;
              fin = 1'b1;
            end
          end
          if (line_done[p]) begin
            // the finished line becomes the reference of the next one
            next_s.proc[p].ref_ls = (p == 0) ? s.proc[p].source_line_start_keep : s.proc[p].destination_line_start_keep;
            next_s.proc[p].source_line_start_keep = s.proc[p].sa_cur;
            next_s.proc[p].destination_line_start_keep = s.proc[p].da_cur;
            if (g3 && (p == 0)) begin
              if (s.proc[p].k_work == 8'h00) begin
                next_s.proc[p].k_work = (s.proc[p].par[7:0] == 8'h00) ? 8'h00 : s.proc[p].par[7:0] - 8'h01;
              end else begin
                next_s.proc[p].k_work = s.proc[p].k_work - 8'h01;
              end
            end
            if (g3 && (p == 1)) begin
              next_s.proc[p].next_2d = !tag_bit;
            end
            if (op == cmr_pkg::OP_SINGLE) begin
              fin = 1'b1;
            end
          end
        end
        default: begin
          fin = 1'b0;
        end
      endcase
      // completion clears the run bit, even over a software write in the same cycle
      if (fin) begin
        next_s.proc[p].run = cmr_pkg::run_idle;
        next_s.proc[p].mcr[cmr_pkg::GO_BIT] = 1'b0;
      end
      if (start) begin
        next_s.proc[p].illegal = 1'b0;
        next_s.proc[p].src_ovf = 1'b0;
        next_s.proc[p].dst_ovf = 1'b0;
        case (wv[cmr_pkg::OP_LO +: 2])
          cmr_pkg::OP_RESET: begin
            next_s.proc[p].sc_work = 16'h0000;
            next_s.proc[p].sa_cur = 16'h0000;
            next_s.proc[p].dc_work = 16'h0000;
            next_s.proc[p].da_cur = 16'h0000;
            next_s.proc[p].source_line_start_keep = 16'h0000;
            next_s.proc[p].destination_line_start_keep = 16'h0000;
            next_s.proc[p].ref_ls = 16'h0000;
            next_s.proc[p].k_work = 8'h00;
            next_s.proc[p].next_2d = 1'b0;
            next_s.proc[p].run = cmr_pkg::run_reset;
            next_s.proc[p].timer = 9'(cmr_pkg::RESET_CYCLES);
            next_s.flush = (p == 0);
          end
          cmr_pkg::OP_SINGLE, cmr_pkg::OP_MULTI: begin
            if (wv[cmr_pkg::MC_LO +: 2] == 2'h3) begin
              next_s.proc[p].illegal = 1'b1;
              next_s.proc[p].mcr[cmr_pkg::GO_BIT] = 1'b0;
            end else begin
              next_s.proc[p].run = cmr_pkg::run_active;
              if (!s.proc[p].rcr[cmr_pkg::RC_SRC_COUNT]) begin
                next_s.proc[p].sc_work = s.proc[p].sc_hold;
              end
              if (!s.proc[p].rcr[cmr_pkg::RC_SRC_ADDR]) begin
                next_s.proc[p].sa_cur = s.proc[p].sa_hold;
              end
              if (!s.proc[p].rcr[cmr_pkg::RC_DST_COUNT]) begin
                next_s.proc[p].dc_work = s.proc[p].dc_hold;
              end
              if (!s.proc[p].rcr[cmr_pkg::RC_DST_ADDR]) begin
                next_s.proc[p].da_cur = s.proc[p].da_hold;
              end
              if (!s.proc[p].rcr[cmr_pkg::RC_SRC_LS]) begin
                next_s.proc[p].source_line_start_keep = s.proc[p].rcr[cmr_pkg::RC_SRC_ADDR] ? s.proc[p].sa_cur
                                                                          : s.proc[p].sa_hold;
              end
              if (!s.proc[p].rcr[cmr_pkg::RC_DST_LS]) begin
                next_s.proc[p].destination_line_start_keep = s.proc[p].rcr[cmr_pkg::RC_DST_ADDR] ? s.proc[p].da_cur
                                                                          : s.proc[p].da_hold;
              end
            end
          end
          default: begin
            next_s.proc[p].illegal = 1'b1; // reserved operation
            next_s.proc[p].mcr[cmr_pkg::GO_BIT] = 1'b0;
          end
        endcase
      end
      next_s.proc[p].busy = next_s.proc[p].run != cmr_pkg::run_idle;
      // coding controls for the datapath, registered
      next_s.proc[p].ctl.pass_through = mode == cmr_pkg::MODE_TRANSPARENT;
      next_s.proc[p].ctl.one_dim = mode == cmr_pkg::MODE_ONE_DIM;
      next_s.proc[p].ctl.two_dim = g3 || g4;
      next_s.proc[p].ctl.eol_insert = g3 || (!g4 && s.proc[p].par[cmr_pkg::PAR_AUTO_EOL]);
      next_s.proc[p].ctl.eol_byte_pad = mode == cmr_pkg::MODE_TRANSPARENT;
      next_s.proc[p].ctl.wrap_enable = !(g3 || g4);
      if (g4) begin
        next_s.proc[p].ctl.line_is_2d = 1'b1;
      end else if (g3) begin
        next_s.proc[p].ctl.line_is_2d = (p == 0) ? (s.proc[p].k_work != 8'h00) : s.proc[p].next_2d;
      end else begin
        next_s.proc[p].ctl.line_is_2d = 1'b0;
      end
      next_s.proc[p].ctl.ref_read = next_s.proc[p].ctl.line_is_2d;
      next_s.proc[p].ctl.unaligned_code_flag = (p == 1) && s.proc[p].rcr[cmr_pkg::RC_UNALIGNED];
      next_s.proc[p].ctl.src_doc = s.proc[p].mcr[cmr_pkg::SC_BIT];
      next_s.proc[p].ctl.dst_doc = s.proc[p].mcr[cmr_pkg::DC_BIT];
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.waitrequest <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // compressor document input queue
  cmr_byte_fifo u_doc_fifo (
    .clk(clk),
    .resetn(resetn),
    .flush(s.flush),
    .in_valid(doc_in_valid),
    .in_data(doc_in_data),
    .in_ready(doc_in_ready),
    .out_valid(doc_out_valid),
    .out_data(doc_out_data),
    .out_ready(doc_out_ready)
  );

  // outputs taken from state flops
  assign readdata = s.readdata;
  assign waitrequest = s.waitrequest;
  generate
    for (genvar g = 0; g < 2; g++) begin : g_out
      assign busy[g] = s.proc[g].busy;
      assign interrupt_enable_bit[g] = s.proc[g].mcr[cmr_pkg::IE_BIT];
      assign ctl[g] = s.proc[g].ctl;
      assign src_addr[g] = s.proc[g].sa_cur;
      assign dst_addr[g] = s.proc[g].da_cur;
      assign ref_addr[g] = s.proc[g].ref_ls;
    end
  endgenerate
endmodule

/* verif/cmr_datapath_model.sv */
// Purpose: datapath stand-in that paces source transfer events
// Assumes: one pulse per enabled processor every gap+1 cycles while busy
// Notes: line end follows a bench request one cycle later; destination and tag stay quiet
`timescale 1ns/1ps
module cmr_datapath_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pacing from bench, busy from design
  input wire logic [1:0] en,
  input wire logic [3:0] gap,
  input wire logic [1:0] line_req,
  input wire logic [1:0] busy,
  // events to the design
  output logic [1:0] src_xfer,
  output logic [1:0] dst_xfer,
  output logic [1:0] line_done,
  output logic tag_bit
);
  logic [3:0] cnt;
  // gap 0 answers every cycle, larger gaps answer slowly
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      src_xfer <= '0;
      line_done <= '0;
    end else begin
      cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
      src_xfer <= (cnt == 4'h0) ? (en & busy) : 2'h0;
      line_done <= line_req & busy;
    end
  end
  // unused event lines held inactive
  assign dst_xfer = 2'h0;
  assign tag_bit = 1'b0;
endmodule

/* verif/cmr_coding_control_checker.sv */
// Purpose: port-level assertions for the coding control bank
// Assumes: one wait cycle per bus access
// Notes: attached by bind from the bench
`timescale 1ns/1ps
module cmr_coding_control_checker (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // processor side
  input wire logic [1:0] src_xfer,
  input wire logic [1:0] busy,
  input wire cmr_pkg::cmr_ctl_type [1:0] ctl,
  input wire logic [1:0][15:0] src_addr
);
  logic go_wr;
  logic bad_cfg;
  // accepted start write to the idle compressor
  assign go_wr = write && !waitrequest && address == 8'h00 && byteenable[0] && writedata[0] && !busy[0];
  assign bad_cfg = writedata[7:6] == 2'h3 || writedata[2:1] == 2'h3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered after one cycle");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("wait release longer than one cycle");
  a_unmapped_zero: assert property (read && !waitrequest && address[7] |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_start_busy: assert property (go_wr && !bad_cfg |=> busy[0])
    else $error("start did not set busy");
  a_reserved_idle: assert property (go_wr && bad_cfg |=> !busy[0] [*3])
    else $error("reserved start ran");
  a_src_step: assert property (src_xfer[0] && busy[0] |=> src_addr[0] == $past(src_addr[0]) + 16'h0001)
    else $error("source address did not step");
  a_mode_onehot: assert property ($onehot0({ctl[0].pass_through, ctl[0].one_dim, ctl[0].two_dim}))
    else $error("more than one coding mode");
  a_pass_pad: assert property (ctl[0].pass_through |-> ctl[0].eol_byte_pad)
    else $error("transparent mode without byte pad");
  a_two_nowrap: assert property (!(ctl[0].two_dim && ctl[0].wrap_enable))
    else $error("wraparound in two-dimensional mode");
  // main scenarios
  c_start: cover property (go_wr && !bad_cfg);
  c_reserved: cover property (go_wr && bad_cfg);
  c_xfer: cover property (src_xfer[0] && busy[0]);
endmodule

/* verif/cmr_coding_control_tb.sv */
// Purpose: self-checking bench for the coding control bank
// Assumes: reads noted in a queue, answers compared by a monitor
// Notes: expander bank sits at 0x40
`timescale 1ns/1ps
module cmr_coding_control_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] src_xfer, dst_xfer, line_done, busy;
  logic tag_bit;
  logic [1:0] en = '0;
  logic [3:0] gap = '0;
  cmr_pkg::cmr_ctl_type [1:0] ctl;
  logic [1:0][15:0] src_addr;
  logic [1:0][15:0] dst_addr, ref_addr;
  logic [1:0] ie;
  logic [1:0] line_req = '0;
  logic doc_in_valid = 1'b0;
  logic [7:0] doc_in_data = '0;
  logic doc_out_ready = 1'b0;
  logic doc_in_ready, doc_out_valid;
  logic [7:0] doc_out_data;
  logic [31:0] exp_q[$];
  logic [31:0] seed;
  logic [15:0] sa, da;
  logic [7:0] d0;
  int err_count = 0;
  int n_compared = 0;
  // clock
  always #4 clk = ~clk;
  cmr_coding_control u_dut (.clk, .resetn, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .src_xfer, .dst_xfer, .line_done, .tag_bit, .busy, .interrupt_enable_bit(ie), .ctl,
    .src_addr, .dst_addr, .ref_addr, .doc_in_valid, .doc_in_data, .doc_in_ready, .doc_out_valid,
    .doc_out_data, .doc_out_ready);
  cmr_datapath_model u_dp (.clk, .resetn, .en, .gap, .line_req, .busy, .src_xfer, .dst_xfer, .line_done,
    .tag_bit);
  function automatic logic [7:0] ra(input int p, input int i);
    return 8'(p * 64 + i * 4);
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) err_count++;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic wait_idle(input int p);
    int n;
    n = 0;
    while (busy[p] !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) err_count++;
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // monitor: oldest noted value against each read answer
  always @(posedge clk) begin
    if (read && !waitrequest) cmp("readdata", exp_q.pop_front(), readdata);
  end
  // watchdog
  initial begin
    #160000;
    err_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    seed = 32'h41a2a466;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int p = 0; p < 2; p++) begin
      wr(ra(p, 0), 32'h0000_0001);
      rd(ra(p, 3), 32'h0000_0001);
      wait_idle(p);
      rd(ra(p, 0), 32'h0000_0000);
      wr(ra(p, 1), 32'h0000_00ff);
      rd(ra(p, 1), p ? 32'h0000_00ef : 32'h0000_00cf);
    end
    // first run reloads everything from holding registers
    sa = 16'($random(seed));
    da = 16'($random(seed));
    gap <= 4'($random(seed)) & 4'h3;
    wr(ra(0, 4), 32'h0000_fff0);
    wr(ra(0, 5), {16'h0000, sa});
    wr(ra(0, 6), 32'h0000_fff0);
    wr(ra(0, 7), {16'h0000, da});
    wr(ra(0, 1), 32'h0000_0000);
    wr(ra(0, 0), 32'h0000_0045);
    rd(ra(0, 8), 32'h0000_fff0);
    rd(ra(0, 9), {16'h0000, sa});
    rd(ra(0, 10), 32'h0000_fff0);
    rd(ra(0, 11), {16'h0000, da});
    rd(ra(0, 12), {16'h0000, sa});
    rd(ra(0, 13), {16'h0000, da});
    en <= 2'h1;
    wait_idle(0);
    en <= 2'h0;
    rd(ra(0, 3), 32'h0000_0004);
    rd(ra(0, 0), 32'h0000_0044);
    // second run keeps addresses and destination count
    wr(ra(0, 6), 32'h0000_fff8);
    wr(ra(0, 7), {16'h0000, da + 16'h0005});
    wr(ra(0, 1), 32'h0000_004e);
    wr(ra(0, 0), 32'h0000_0045);
    rd(ra(0, 8), 32'h0000_fff0);
    rd(ra(0, 9), {16'h0000, sa + 16'h0010});
    rd(ra(0, 10), 32'h0000_fff0);
    rd(ra(0, 11), {16'h0000, da});
    rd(ra(0, 12), {16'h0000, sa});
    rd(ra(0, 13), {16'h0000, da});
    cmp("dst_addr", {16'h0000, da}, {16'h0000, dst_addr[0]});
    gap <= 4'h0;
    en <= 2'h1;
    wait_idle(0);
    en <= 2'h0;
    // reserved mode and reserved operation
    wr(ra(0, 0), 32'h0000_0001);
    wait_idle(0);
    wr(ra(0, 0), 32'h0000_00c5);
    rd(ra(0, 3), 32'h0000_0002);
    rd(ra(0, 0), 32'h0000_00c4);
    wr(ra(1, 0), 32'h0000_0047);
    rd(ra(1, 3), 32'h0000_0002);
    // coding mode decode
    for (int m = 0; m < 3; m++) begin
      wr(ra(0, 0), (32'(m) << 6) | 32'h0000_0038);
      repeat (2) @(posedge clk);
      cmp("ie", 32'h1, 32'(ie[0]));
      cmp("doc_sel", 32'h3, 32'({ctl[0].src_doc, ctl[0].dst_doc}));
      cmp("pass_through", 32'(m == 0), 32'(ctl[0].pass_through));
      cmp("one_dim", 32'(m == 1), 32'(ctl[0].one_dim));
      cmp("two_dim", 32'(m == 2), 32'(ctl[0].two_dim));
    end
    wr(ra(0, 2), 32'h0000_0002);
    repeat (2) @(posedge clk);
    cmp("eol_insert", 32'h1, 32'(ctl[0].eol_insert));
    wr(ra(0, 2), 32'h0000_0300);
    repeat (2) @(posedge clk);
    cmp("eol_insert", 32'h0, 32'(ctl[0].eol_insert));
    wr(ra(1, 1), 32'h0000_0020);
    repeat (2) @(posedge clk);
    cmp("unaligned", 32'h1, 32'(ctl[1].unaligned_code_flag));
    wr(8'h80, $random(seed));
    rd(8'h80, 32'h0000_0000);
    // group 3 compression with k=3: one 1d line, two 2d lines, then 1d again
    wr(ra(0, 2), 32'h0000_0003);
    wr(ra(0, 1), 32'h0000_0040);
    wr(ra(0, 0), 32'h0000_0085);
    for (int i = 0; i < 4; i++) begin
      repeat (3) @(posedge clk);
      cmp("line_is_2d", 32'(i == 1 || i == 2), 32'(ctl[0].line_is_2d));
      cmp("ref_read", 32'(i == 1 || i == 2), 32'(ctl[0].ref_read));
      cmp("ref_addr", (i >= 2) ? {16'h0000, sa} : 32'h0000_0000, {16'h0000, ref_addr[0]});
      line_req <= 2'h1;
      @(posedge clk);
      line_req <= 2'h0;
    end
    // document fifo fills to three and drains
    d0 = 8'($random(seed));
    doc_in_data <= d0;
    doc_in_valid <= 1'b1;
    repeat (6) @(posedge clk);
    cmp("doc_in_ready", 32'h0, 32'(doc_in_ready));
    cmp("doc_out_data", 32'(d0), 32'(doc_out_data));
    doc_in_valid <= 1'b0;
    doc_out_ready <= 1'b1;
    repeat (3) @(posedge clk);
    cmp("doc_out_valid", 32'h1, 32'(doc_out_valid));
    @(posedge clk);
    cmp("doc_out_valid", 32'h0, 32'(doc_out_valid));
    end_of_test();
  end
endmodule
bind cmr_coding_control cmr_coding_control_checker u_chk (.clk, .resetn, .address, .read, .write, .writedata,
  .byteenable, .readdata, .waitrequest, .src_xfer, .busy, .ctl, .src_addr);
